/* File: common/bof_params.svh */
// Purpose: constants for the boot order and flash ownership sequencer
// Assumes: included by bare name from package and design files
// Notes: mode-select codes and timing figures are named here once
`ifndef BOF_PARAMS_SVH
`define BOF_PARAMS_SVH

// ----------------------------------------------------------------
// mode-select pin codes
// ----------------------------------------------------------------
`define BOF_MODE_SELECT_PINS_W 3
`define BOF_MODE_SELECT_PINS_STREAM8 3'h0
`define BOF_MODE_SELECT_PINS_STREAM32 3'h1
`define BOF_MODE_SELECT_PINS_QSPI_FAST 3'h2
`define BOF_MODE_SELECT_PINS_QSPI_NORM 3'h3
`define BOF_MODE_SELECT_PINS_SDMMC 3'h4
`define BOF_MODE_SELECT_PINS_PCIE 3'h5
`define BOF_MODE_SELECT_PINS_JTAG 3'h7

// ----------------------------------------------------------------
// security and boot source fields
// ----------------------------------------------------------------
`define BOF_FUSE_W 4
`define BOF_SEC_W 2
`define BOF_SEC_OPEN 2'h0
`define BOF_SEC_AUTH 2'h1
`define BOF_SEC_ENC 2'h2
`define BOF_FUSE_AUTH_BIT 0
`define BOF_FUSE_ENC_BIT 1
`define BOF_SECONDARY_CORES 3
`define BOF_SEC_CORES_WAIT 3'h7
`define BOF_SEC_CORES_RUN 3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BOF_CLK_MHZ 200
`define BOF_FLASH_RST_NS 50
`define BOF_FLASH_RST_CYC ((`BOF_FLASH_RST_NS * `BOF_CLK_MHZ + 999) / 1000)
`define BOF_FLASH_MAX_MHZ 108
`define BOF_FLASH_MULTI_MHZ 54
`define BOF_FLASH_REF_HZ 32'h0BEBC200
`define BOF_MAX_CS 4
`define BOF_CNT_W 8

`endif

/* File: common/bof_pkg.sv */
// Purpose: types shared by the sequencer and the flash owner
// Assumes: bof_params.svh supplies widths
// Notes: one-hot state codes are written out
`include "bof_params.svh"

package bof_pkg;

  // ----------------------------------------------------------------
  // sampled boot configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`BOF_MODE_SELECT_PINS_W-1:0] scheme;
    logic [`BOF_SEC_W-1:0] secLevel;
    logic fabricFirst;
    logic flashSource;
  } bof_mode_t;

  // ----------------------------------------------------------------
  // pin state towards the processor-side and fabric I/O
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fabricIoActive;
    logic procIoActive;
    logic procIoResetVal;
    logic memPinsEnable;
    logic debugEnable;
  } bof_pins_t;

  typedef enum logic [11:0] {
    SEQ_POR = 12'h001,
    SEQ_SAMPLE = 12'h002,
    SEQ_SECURE = 12'h004,
    SEQ_FIRMWARE = 12'h008,
    SEQ_FABRIC = 12'h010,
    SEQ_MEMPINS = 12'h020,
    SEQ_LOADER = 12'h040,
    SEQ_RELEASE = 12'h080,
    SEQ_RUN = 12'h100,
    SEQ_PHASE2 = 12'h200,
    SEQ_HOLD = 12'h400,
    SEQ_ERROR = 12'h800
  } bof_seq_t;

  typedef enum logic [2:0] {
    OWN_MANAGER = 3'h1,
    OWN_RESET = 3'h2,
    OWN_PROC = 3'h4
  } bof_own_t;

endpackage

/* File: verilog/bof_flash_owner.sv */
// Purpose: hands the shared quad serial flash controller to the processor
// Assumes: request held by the processor until granted or dropped
// Notes: the processor has no reset, clock gate or DMA path here
`timescale 1ns/1ps
`include "bof_params.svh"

module bof_flash_owner
  import bof_pkg::*;
#(
  parameter int RST_CYC = `BOF_FLASH_RST_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic allowed,
  input wire logic request,
  output logic grant,
  output logic ctrlResetN,
  output logic [31:0] refClkHz,
  output logic refClkValid
);

  initial begin
    if (RST_CYC < 1 || RST_CYC > 255) begin
      $error("bof_flash_owner: RST_CYC out of range");
    end
  end

  bof_own_t own_q, own_d;
  logic [`BOF_CNT_W-1:0] cnt_q, cnt_d;
  wire rstDone = (cnt_q == `BOF_CNT_W'(RST_CYC - 1));
  wire want = allowed && request;

  // ----------------------------------------------------------------
  // ownership
  // ----------------------------------------------------------------
  always_comb begin
    own_d = own_q;
    cnt_d = cnt_q;
    case (own_q)
      OWN_MANAGER: begin
        cnt_d = '0;
        if (want) begin
          own_d = OWN_RESET;
        end
      end
      OWN_RESET: begin
        cnt_d = cnt_q + 1'b1;
        // controller reset before the processor may touch it
        if (!want) begin
          own_d = OWN_MANAGER;
        end else if (rstDone) begin
          own_d = OWN_PROC;
        end
      end
      OWN_PROC: begin
        if (!want) begin
          own_d = OWN_MANAGER;
        end
      end
      default: own_d = OWN_MANAGER;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      own_q <= OWN_MANAGER;
      cnt_q <= '0;
      grant <= 1'b0;
      ctrlResetN <= 1'b1;
      refClkHz <= 32'h00000000;
      refClkValid <= 1'b0;
    end else if (clkEn) begin
      own_q <= own_d;
      cnt_q <= cnt_d;
      // grant and clock report rise together so no early access
      grant <= (own_d == OWN_PROC);
      ctrlResetN <= (own_d != OWN_RESET);
      refClkValid <= (own_d == OWN_PROC);
      refClkHz <= (own_d == OWN_PROC) ? `BOF_FLASH_REF_HZ : 32'h00000000;
    end
  end

endmodule // bof_flash_owner

/* File: verilog/bof_sequencer.sv */
// Purpose: start-up sequencing and flash ownership of the device
// Assumes: firmware fetch, fabric load and loader copy are done by
//   datapaths outside; they answer with level done/ok inputs
// Notes: one clock, synchronous active-low reset, clkEn freezes all
`timescale 1ns/1ps
`include "bof_params.svh"

module bof_sequencer
  import bof_pkg::*;
#(
  parameter int NUM_CS = 1,
  parameter int FLASH_RST_CYC = `BOF_FLASH_RST_CYC,
  parameter logic [7:0] FLASH_PINMUX = 8'h00
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [`BOF_MODE_SELECT_PINS_W-1:0] modeSelectPins,
  input wire logic fabricFirstStrap,
  input wire logic [`BOF_FUSE_W-1:0] fuseValue,
  input wire logic fwLoadDone,
  input wire logic fwAuthOk,
  input wire logic fabricCfgDone,
  input wire logic memPinsDone,
  input wire logic loaderLoadDone,
  input wire logic procBootEnable,
  input wire logic debugRequest,
  input wire logic fabricCfgReq,
  input wire logic flashOwnReq,
  output bof_mode_t mode_q,
  output bof_pins_t pins_q,
  output logic fwLoadStart_q,
  output logic fabricCfgStart_q,
  output logic memPinsStart_q,
  output logic loaderLoadStart_q,
  output logic procResetN_q,
  output logic primaryRun_q,
  output logic [`BOF_SECONDARY_CORES-1:0] secondaryWait_q,
  output logic fabricUserMode_q,
  output logic fabricCfgAck_q,
  output logic cfgError_q,
  output logic flashGrant_q,
  output logic flashCtrlResetN_q,
  output logic [31:0] flashRefClkHz_q,
  output logic flashRefClkValid_q,
  output logic [7:0] flashPinmux_q,
  output logic [7:0] flashClkDiv_q,
  output logic [1:0] flashCsCount_q
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (NUM_CS < 1 || NUM_CS > `BOF_MAX_CS) begin
      $error("bof_sequencer: NUM_CS must be 1 to 4");
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic isFlashScheme(input logic [`BOF_MODE_SELECT_PINS_W-1:0] m);
    isFlashScheme = (m == `BOF_MODE_SELECT_PINS_QSPI_FAST) ||
                    (m == `BOF_MODE_SELECT_PINS_QSPI_NORM);
  endfunction

  function automatic logic [`BOF_SEC_W-1:0] secFromFuse(
    input logic [`BOF_FUSE_W-1:0] f);
    if (f[`BOF_FUSE_ENC_BIT]) begin
      secFromFuse = `BOF_SEC_ENC;
    end else if (f[`BOF_FUSE_AUTH_BIT]) begin
      secFromFuse = `BOF_SEC_AUTH;
    end else begin
      secFromFuse = `BOF_SEC_OPEN;
    end
  endfunction

  // flash clock divider: ceiling of reference over the allowed maximum
  localparam int FLASH_MHZ = (NUM_CS > 1) ? `BOF_FLASH_MULTI_MHZ :
                             `BOF_FLASH_MAX_MHZ;
  localparam int FLASH_DIV = (`BOF_CLK_MHZ + FLASH_MHZ - 1) / FLASH_MHZ;
  localparam logic [7:0] FLASH_DIV_W = 8'(FLASH_DIV);
  localparam logic [1:0] CS_COUNT_W = 2'(NUM_CS - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bof_seq_t seq_q, seq_d;
  bof_mode_t modeNext;
  logic fabricDone_q;

  wire inFabricFirst = mode_q.fabricFirst;
  wire pcieScheme = (modeSelectPins == `BOF_MODE_SELECT_PINS_PCIE);
  wire pcieBad = pcieScheme && !fabricFirstStrap;
  wire fwReady = fwLoadDone && fwAuthOk;
  wire fwFail = fwLoadDone && !fwAuthOk;
  wire procRunning = (seq_q == SEQ_RUN) || (seq_q == SEQ_PHASE2);
  wire flashAllowed = procRunning && mode_q.flashSource;
  wire phase2Ask = (seq_q == SEQ_RUN) && !inFabricFirst &&
                   !fabricDone_q && fabricCfgReq;

  // mode latched once, after reset release, never from reset itself
  always_comb begin
    modeNext.scheme = modeSelectPins;
    modeNext.secLevel = secFromFuse(fuseValue);
    modeNext.fabricFirst = fabricFirstStrap;
    modeNext.flashSource = isFlashScheme(modeSelectPins);
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_POR: seq_d = SEQ_SAMPLE;
      SEQ_SAMPLE: begin
        if (pcieBad) begin
          seq_d = SEQ_ERROR;
        end else begin
          seq_d = SEQ_SECURE;
        end
      end
      SEQ_SECURE: seq_d = SEQ_FIRMWARE;
      SEQ_FIRMWARE: begin
        if (fwFail) begin
          seq_d = SEQ_ERROR;
        end else if (fwReady && inFabricFirst) begin
          seq_d = SEQ_FABRIC;
        end else if (fwReady) begin
          seq_d = SEQ_MEMPINS;
        end
      end
      SEQ_FABRIC: begin
        if (fabricCfgDone && procBootEnable) begin
          seq_d = SEQ_MEMPINS;
        end else if (fabricCfgDone) begin
          seq_d = SEQ_HOLD;
        end
      end
      SEQ_MEMPINS: begin
        if (memPinsDone) begin
          seq_d = SEQ_LOADER;
        end
      end
      SEQ_LOADER: begin
        if (loaderLoadDone) begin
          seq_d = SEQ_RELEASE;
        end
      end
      SEQ_RELEASE: seq_d = SEQ_RUN;
      SEQ_RUN: begin
        if (phase2Ask) begin
          seq_d = SEQ_PHASE2;
        end
      end
      SEQ_PHASE2: begin
        if (fabricCfgDone) begin
          seq_d = SEQ_RUN;
        end
      end
      SEQ_HOLD: begin
        // late boot enable still allowed after fabric-only start
        if (procBootEnable) begin
          seq_d = SEQ_MEMPINS;
        end
      end
      SEQ_ERROR: seq_d = SEQ_ERROR;
      default: seq_d = SEQ_POR;
    endcase
  end

  wire enterFw = (seq_q == SEQ_SECURE);
  wire enterFabric = (seq_q == SEQ_FIRMWARE) && (seq_d == SEQ_FABRIC);
  wire enterPhase2 = (seq_q == SEQ_RUN) && (seq_d == SEQ_PHASE2);
  wire enterMem = (seq_q != SEQ_MEMPINS) && (seq_d == SEQ_MEMPINS);
  wire enterLoader = (seq_q == SEQ_MEMPINS) && (seq_d == SEQ_LOADER);
  wire fabricFinish = ((seq_q == SEQ_FABRIC) || (seq_q == SEQ_PHASE2)) &&
                      fabricCfgDone;
  wire releaseNow = (seq_q == SEQ_RELEASE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seq_q <= SEQ_POR;
    end else if (clkEn) begin
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= '0;
    end else if (clkEn && seq_q == SEQ_SAMPLE) begin
      mode_q <= modeNext;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fabricDone_q <= 1'b0;
      fabricUserMode_q <= 1'b0;
    end else if (clkEn && fabricFinish) begin
      fabricDone_q <= 1'b1;
      fabricUserMode_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // start strobes, one cycle each; cfgError_q held while in SEQ_ERROR
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fwLoadStart_q <= 1'b0;
      fabricCfgStart_q <= 1'b0;
      memPinsStart_q <= 1'b0;
      loaderLoadStart_q <= 1'b0;
      fabricCfgAck_q <= 1'b0;
      cfgError_q <= 1'b0;
    end else if (clkEn) begin
      fwLoadStart_q <= enterFw;
      fabricCfgStart_q <= enterFabric || enterPhase2;
      memPinsStart_q <= enterMem;
      loaderLoadStart_q <= enterLoader;
      fabricCfgAck_q <= enterPhase2;
      cfgError_q <= (seq_d == SEQ_ERROR);
    end
  end

  // ----------------------------------------------------------------
  // pins, reset and cores
  // ----------------------------------------------------------------
  wire fabricIoNext = fabricFinish || fabricDone_q;
  wire procIoNext = fabricIoNext && inFabricFirst;
  wire holdNext = (seq_d == SEQ_HOLD);
  wire memPinsNext = enterLoader || pins_q.memPinsEnable;
  wire debugNext = (enterLoader && debugRequest) || pins_q.debugEnable;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins_q <= '0;
      procResetN_q <= 1'b0;
      primaryRun_q <= 1'b0;
      secondaryWait_q <= `BOF_SEC_CORES_RUN;
    end else if (clkEn) begin
      pins_q.fabricIoActive <= fabricIoNext;
      pins_q.procIoActive <= procIoNext;
      pins_q.procIoResetVal <= holdNext;
      pins_q.memPinsEnable <= memPinsNext;
      pins_q.debugEnable <= debugNext;
      if (releaseNow) begin
        procResetN_q <= 1'b1;
        primaryRun_q <= 1'b1;
        secondaryWait_q <= inFabricFirst ? `BOF_SEC_CORES_WAIT :
                           `BOF_SEC_CORES_RUN;
      end else if (holdNext) begin
        procResetN_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // flash controller ownership
  // ----------------------------------------------------------------
  logic ownGrant;
  logic ownRstN;
  logic [31:0] ownRef;
  logic ownRefValid;

  bof_flash_owner #(
    .RST_CYC(FLASH_RST_CYC)
  ) u_owner (
    .clock(clock),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .allowed(flashAllowed),
    .request(flashOwnReq),
    .grant(ownGrant),
    .ctrlResetN(ownRstN),
    .refClkHz(ownRef),
    .refClkValid(ownRefValid)
  );

  // extra stage keeps grant, reset and clock report aligned at the pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flashGrant_q <= 1'b0;
      flashCtrlResetN_q <= 1'b1;
      flashRefClkHz_q <= 32'h00000000;
      flashRefClkValid_q <= 1'b0;
      flashPinmux_q <= 8'h00;
      flashClkDiv_q <= 8'h00;
      flashCsCount_q <= 2'h0;
    end else if (clkEn) begin
      flashGrant_q <= ownGrant;
      flashCtrlResetN_q <= ownRstN;
      flashRefClkHz_q <= ownRef;
      flashRefClkValid_q <= ownRefValid;
      flashPinmux_q <= FLASH_PINMUX;
      flashClkDiv_q <= FLASH_DIV_W;
      flashCsCount_q <= CS_COUNT_W;
    end
  end

endmodule // bof_sequencer

/* File: test/bof_sequencer_monitor.sv */
// Purpose: port properties of the boot order and flash ownership sequencer
// Assumes: clkEn held high by the bench
// Notes: bound to bof_sequencer at the foot of this file
`timescale 1ns/1ps
`include "bof_params.svh"

module bof_sequencer_monitor
  import bof_pkg::*;
#(
  parameter int FLASH_RST_CYC = 10,
  parameter int NUM_CS = 1,
  parameter logic [7:0] FLASH_PINMUX = 8'h00
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fabricCfgReq,
  input wire logic flashOwnReq,
  input bof_mode_t mode_q,
  input bof_pins_t pins_q,
  input wire logic fwLoadStart_q,
  input wire logic fabricCfgStart_q,
  input wire logic memPinsStart_q,
  input wire logic loaderLoadStart_q,
  input wire logic procResetN_q,
  input wire logic primaryRun_q,
  input wire logic [`BOF_SECONDARY_CORES-1:0] secondaryWait_q,
  input wire logic fabricUserMode_q,
  input wire logic fabricCfgAck_q,
  input wire logic cfgError_q,
  input wire logic flashGrant_q,
  input wire logic flashCtrlResetN_q,
  input wire logic [31:0] flashRefClkHz_q,
  input wire logic flashRefClkValid_q,
  input wire logic [7:0] flashPinmux_q,
  input wire logic [1:0] flashCsCount_q
);
  // ----------------------------------------------------------------
  // length of the controller reset pulse
  // ----------------------------------------------------------------
  logic [7:0] rstLow_q;
  always_ff @(posedge clock) begin
    if (!rst_n || flashCtrlResetN_q) rstLow_q <= 8'h00;
    else rstLow_q <= rstLow_q + 8'h01;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_reset_state: assert property (disable iff (1'b0)
    !rst_n |=> !procResetN_q && flashCtrlResetN_q && !flashGrant_q)
    else $error("outputs not at reset values");
  a_grant_qspi: assert property (
    flashGrant_q |-> mode_q.scheme == `BOF_MODE_SELECT_PINS_QSPI_FAST ||
      mode_q.scheme == `BOF_MODE_SELECT_PINS_QSPI_NORM)
    else $error("flash granted outside quad flash scheme");
  a_grant_clock: assert property (
    $rose(flashGrant_q) |-> !$past(flashCtrlResetN_q) &&
      flashRefClkValid_q && flashRefClkHz_q == `BOF_FLASH_REF_HZ)
    else $error("grant without controller reset or clock");
  a_reset_length: assert property (
    $rose(flashGrant_q) |-> rstLow_q == FLASH_RST_CYC)
    else $error("controller reset pulse of wrong length");
  a_grant_release: assert property (
    flashGrant_q && !flashOwnReq |-> ##2 !flashGrant_q)
    else $error("grant kept after request dropped");
  a_fabric_hiz: assert property (
    !mode_q.fabricFirst && !procResetN_q |-> !pins_q.fabricIoActive)
    else $error("fabric pins driven while processor boots");
  a_release_ready: assert property (
    $rose(procResetN_q) |-> pins_q.memPinsEnable && (!mode_q.fabricFirst
      || fabricUserMode_q && pins_q.procIoActive))
    else $error("processor released too early");
  a_core_wait: assert property (
    $rose(procResetN_q) |-> primaryRun_q &&
      secondaryWait_q == (mode_q.fabricFirst ? 3'h7 : 3'h0))
    else $error("core run state wrong at release");
  a_hold_pins: assert property (
    $rose(pins_q.procIoResetVal) |-> !procResetN_q &&
      pins_q.procIoActive && pins_q.fabricIoActive)
    else $error("unbooted processor pins wrong");
  a_phase_two: assert property (
    fabricCfgAck_q |-> procResetN_q && !mode_q.fabricFirst &&
      $past(fabricCfgReq))
    else $error("phase two acknowledged without cause");
  a_mode_frozen: assert property (
    $past(procResetN_q) |-> $stable(mode_q))
    else $error("mode changed after sampling");
  a_pcie_order: assert property (
    $rose(fwLoadStart_q) |-> !(mode_q.scheme == `BOF_MODE_SELECT_PINS_PCIE &&
      !mode_q.fabricFirst))
    else $error("pcie scheme accepted in processor-first order");
  a_mux_fixed: assert property (
    procResetN_q |-> flashPinmux_q == FLASH_PINMUX &&
      flashCsCount_q == NUM_CS - 1)
    else $error("flash pin mux or select count changed");
  a_fabric_start: assert property (
    fabricCfgStart_q |-> !pins_q.fabricIoActive &&
      (fabricCfgAck_q || !procResetN_q))
    else $error("bad fabric start");
  a_start_order: assert property (
    memPinsStart_q || loaderLoadStart_q |-> !procResetN_q &&
      pins_q.memPinsEnable == loaderLoadStart_q)
    else $error("bad pin or loader start");

  c_grant: cover property ($rose(flashGrant_q));
  c_phase_two: cover property (fabricCfgAck_q);
  c_error: cover property ($rose(cfgError_q));
  c_release: cover property ($rose(procResetN_q));
endmodule // bof_sequencer_monitor

bind bof_sequencer bof_sequencer_monitor #(
  .FLASH_RST_CYC(FLASH_RST_CYC), .NUM_CS(NUM_CS),
  .FLASH_PINMUX(FLASH_PINMUX)
) mon (
  .clock(clock), .rst_n(rst_n), .fabricCfgReq(fabricCfgReq),
  .flashOwnReq(flashOwnReq), .mode_q(mode_q), .pins_q(pins_q),
  .fwLoadStart_q(fwLoadStart_q), .procResetN_q(procResetN_q),
  .fabricCfgStart_q(fabricCfgStart_q), .memPinsStart_q(memPinsStart_q),
  .primaryRun_q(primaryRun_q), .secondaryWait_q(secondaryWait_q),
  .fabricUserMode_q(fabricUserMode_q), .fabricCfgAck_q(fabricCfgAck_q),
  .cfgError_q(cfgError_q), .flashGrant_q(flashGrant_q),
  .flashCtrlResetN_q(flashCtrlResetN_q), .flashRefClkHz_q(flashRefClkHz_q),
  .flashRefClkValid_q(flashRefClkValid_q), .flashPinmux_q(flashPinmux_q),
  .flashCsCount_q(flashCsCount_q), .loaderLoadStart_q(loaderLoadStart_q)
);

/* File: test/bof_proc_model.sv */
// Purpose: processor-side firmware asking for fabric config and flash
// Assumes: bench commands are levels
// Notes: learns the flash clock only once granted
`timescale 1ns/1ps

module bof_proc_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfgCmd,
  input wire logic flashCmd,
  input wire logic fabricCfgAck,
  input wire logic flashGrant,
  input wire logic flashRefClkValid,
  input wire logic [31:0] flashRefClkHz,
  output logic fabricCfgReq,
  output logic flashOwnReq,
  output logic [31:0] refHz
);
  logic cfgSeen_q;

  always_ff @(posedge clock) begin
    if (!rst_n || !cfgCmd) begin
      fabricCfgReq <= 1'b0;
      cfgSeen_q <= 1'b0;
    end else if (fabricCfgAck) begin
      fabricCfgReq <= 1'b0;
      cfgSeen_q <= 1'b1;
    end else if (!cfgSeen_q) begin
      fabricCfgReq <= 1'b1;
    end
  end

  // no flash access before grant and clock: only then is refHz known
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flashOwnReq <= 1'b0;
      refHz <= 32'h0;
    end else begin
      flashOwnReq <= flashCmd;
      if (flashGrant && flashRefClkValid) refHz <= flashRefClkHz;
    end
  end
endmodule // bof_proc_model

/* File: test/bof_sequencer_tb.sv */
// Purpose: self-checking bench for the boot sequencer
// Assumes: outside datapaths answer done at once unless held
// Notes: short flash reset count keeps the run brief
`timescale 1ns/1ps
`include "bof_params.svh"

module bof_sequencer_tb;
  import bof_pkg::*;
  localparam int RC = 4;
  localparam int NCS = 3;
  localparam logic [7:0] MUX = 8'h5A;
  // stim: mode pins, order strap, fuses, boot, debug, auth
  typedef struct packed {
    logic [10:0] stim;
    logic [6:0] mode;
    logic [4:0] pins;
    logic err;
    logic rstn;
    logic [2:0] cores;
  } bof_row_t;
  bof_row_t rows [8] = '{'{11'h287, 7'h23, 5'h1B, 1'b0, 1'b1, 3'h7},
    '{11'h30D, 7'h35, 5'h02, 1'b0, 1'b1, 3'h0},
    '{11'h491, 7'h4A, 5'h1C, 1'b0, 1'b0, 3'h0},
    '{11'h51D, 7'h58, 5'h00, 1'b1, 1'b0, 3'h0},
    '{11'h58D, 7'h56, 5'h1A, 1'b0, 1'b1, 3'h7},
    '{11'h704, 7'h70, 5'h00, 1'b1, 1'b0, 3'h0},
    '{11'h007, 7'h00, 5'h03, 1'b0, 1'b1, 3'h0},
    '{11'h185, 7'h12, 5'h1A, 1'b0, 1'b1, 3'h7}};
  logic clock = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  logic [2:0] modeSelectPins = 3'h0;
  logic [3:0] fuseValue = 4'h0;
  logic fabricFirstStrap = 1'b0, fwLoadDone = 1'b1, fwAuthOk = 1'b1;
  logic fabricCfgDone = 1'b1, memPinsDone = 1'b1, loaderLoadDone = 1'b1;
  logic procBootEnable = 1'b0, debugRequest = 1'b0;
  logic cfgCmd = 1'b0, flashCmd = 1'b0, hit;
  logic fabricCfgReq, flashOwnReq, procResetN_q, fabricCfgAck_q;
  logic cfgError_q, flashGrant_q, flashCtrlResetN_q, flashRefClkValid_q;
  logic [31:0] flashRefClkHz_q, refHz;
  logic [7:0] flashPinmux_q, flashClkDiv_q;
  logic [1:0] flashCsCount_q;
  logic [2:0] secondaryWait_q;
  bof_mode_t mode_q;
  bof_pins_t pins_q;
  int failures = 0, tests_run = 0;

  always #2.5 clock = ~clock;

  bof_sequencer #(.NUM_CS(NCS), .FLASH_RST_CYC(RC), .FLASH_PINMUX(MUX)) dut (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .modeSelectPins(modeSelectPins), .fabricFirstStrap(fabricFirstStrap),
    .fuseValue(fuseValue), .fwLoadDone(fwLoadDone), .fwAuthOk(fwAuthOk),
    .fabricCfgDone(fabricCfgDone), .memPinsDone(memPinsDone),
    .loaderLoadDone(loaderLoadDone), .procBootEnable(procBootEnable),
    .debugRequest(debugRequest), .fabricCfgReq(fabricCfgReq),
    .flashOwnReq(flashOwnReq), .mode_q(mode_q), .pins_q(pins_q),
    .fwLoadStart_q(), .fabricCfgStart_q(), .memPinsStart_q(),
    .loaderLoadStart_q(), .procResetN_q(procResetN_q), .primaryRun_q(),
    .secondaryWait_q(secondaryWait_q), .fabricUserMode_q(),
    .fabricCfgAck_q(fabricCfgAck_q), .cfgError_q(cfgError_q),
    .flashGrant_q(flashGrant_q), .flashCtrlResetN_q(flashCtrlResetN_q),
    .flashRefClkHz_q(flashRefClkHz_q), .flashRefClkValid_q(flashRefClkValid_q),
    .flashPinmux_q(flashPinmux_q), .flashClkDiv_q(flashClkDiv_q),
    .flashCsCount_q(flashCsCount_q));

  bof_proc_model proc (.clock(clock), .rst_n(rst_n), .cfgCmd(cfgCmd),
    .flashCmd(flashCmd), .fabricCfgAck(fabricCfgAck_q),
    .flashGrant(flashGrant_q), .flashRefClkValid(flashRefClkValid_q),
    .flashRefClkHz(flashRefClkHz_q), .fabricCfgReq(fabricCfgReq),
    .flashOwnReq(flashOwnReq), .refHz(refHz));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic cond(input int w);
    case (w)
      0: return procResetN_q === 1'b1 || cfgError_q === 1'b1 ||
           pins_q.procIoResetVal === 1'b1;
      1: return fabricCfgAck_q === 1'b1;
      2: return flashGrant_q === 1'b1;
      3: return flashGrant_q === 1'b0;
      4: return procResetN_q === 1'b1;
      default: return pins_q.fabricIoActive === 1'b1;
    endcase
  endfunction

  // sampled on the falling edge so registered outputs have settled
  task automatic waitc(input int w, input int lim, input logic must);
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++) begin
      @(negedge clock);
      hit = cond(w);
    end
    if (must && !hit) begin
      failures++;
      $display("[ERR] wait %0d expected event seen none", w);
      end_of_test();
    end
  endtask

  task automatic boot(input logic [10:0] s);
    @(posedge clock);
    rst_n <= 1'b0;
    {modeSelectPins, fabricFirstStrap, fuseValue} <= s[10:3];
    {procBootEnable, debugRequest, fwAuthOk} <= s[2:0];
    {fabricCfgDone, cfgCmd, flashCmd} <= 3'h4;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    waitc(0, 60, 1'b1);
    repeat (2) @(negedge clock);
  endtask

  initial begin
    for (int i = 0; i < 8; i++) begin
      boot(rows[i].stim);
      check("mode", 32'(mode_q), 32'(rows[i].mode));
      check("pins", 32'(pins_q), 32'(rows[i].pins));
      check("error", 32'(cfgError_q), 32'(rows[i].err));
      check("release", 32'(procResetN_q), 32'(rows[i].rstn));
      check("cores", 32'(secondaryWait_q), 32'(rows[i].cores));
    end
    // late boot out of the hold state, then a reset in mid-run
    boot(11'h491);
    @(posedge clock);
    procBootEnable <= 1'b1;
    waitc(4, 40, 1'b1);
    check("late cores", 32'(secondaryWait_q), 32'h7);
    check("late mem pins", 32'(pins_q.memPinsEnable), 32'h1);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(negedge clock);
    check("reset release", 32'(procResetN_q), 32'h0);
    check("reset pins", 32'(pins_q), 32'h0);
    check("reset flash", 32'(flashCtrlResetN_q), 32'h1);
    // processor-first: phase two, then flash ownership
    boot(11'h205);
    check("grant at rest", 32'(flashGrant_q), 32'h0);
    check("fabric hiz", 32'(pins_q.fabricIoActive), 32'h0);
    @(posedge clock);
    fabricCfgDone <= 1'b0;
    cfgCmd <= 1'b1;
    modeSelectPins <= 3'h4;
    waitc(1, 20, 1'b1);
    check("phase2 hiz", 32'(pins_q.fabricIoActive), 32'h0);
    @(posedge clock);
    fabricCfgDone <= 1'b1;
    waitc(5, 20, 1'b1);
    check("phase2 proc io", 32'(pins_q.procIoActive), 32'h0);
    @(posedge clock);
    cfgCmd <= 1'b0;
    @(posedge clock);
    cfgCmd <= 1'b1;
    waitc(1, 20, 1'b0);
    check("second phase2", 32'(hit), 32'h0);
    @(posedge clock);
    flashCmd <= 1'b1;
    waitc(2, 40, 1'b1);
    @(negedge clock);
    check("ref clock", refHz, `BOF_FLASH_REF_HZ);
    check("scheme kept", 32'(mode_q.scheme), 32'h2);
    check("pinmux", 32'(flashPinmux_q), 32'(MUX));
    check("cs count", 32'(flashCsCount_q), 32'(NCS - 1));
    check("clk div", 32'(flashClkDiv_q), 32'h4);
    @(posedge clock);
    flashCmd <= 1'b0;
    waitc(3, 10, 1'b1);
    check("ref cleared", flashRefClkHz_q, 32'h0);
    // secure digital card scheme never hands the flash over
    boot(11'h405);
    @(posedge clock);
    flashCmd <= 1'b1;
    waitc(2, 30, 1'b0);
    check("grant refused", 32'(hit), 32'h0);
    end_of_test();
  end
endmodule // bof_sequencer_tb
